// ### logic/input_limit_pkg.sv
// Package: register map, codes, states and carriers of the input limit block
package input_limit_pkg;

  // --------------------------------------------------------------------
  // Register map
  // --------------------------------------------------------------------
  localparam logic [7:0] ADDR_FAULT_STATUS = 8'h04;
  localparam logic [7:0] ADDR_VBUS_DETECT  = 8'h07;
  localparam logic [7:0] ADDR_SAFE_ZERO    = 8'h0a;
  localparam logic [7:0] ADDR_MANUAL_CTRL  = 8'h21;
  localparam logic [7:0] ADDR_AUTO_STATUS  = 8'h22;

  // Field positions
  localparam int BIT_OVERCURRENT  = 0;
  localparam int BIT_RUNAWAY      = 1;
  localparam int BIT_POWER_GOOD   = 2;
  localparam int BIT_VBUS_DETECT  = 0;
  localparam int BIT_SAFE_ZERO    = 0;
  localparam int BIT_LIMIT_FORCE  = 7;
  localparam int LIMIT_CODE_MSB   = 4;

  // Reset values
  localparam logic [7:0] MANUAL_CTRL_RESET = 8'h00;
  localparam logic [3:0] BUCK_CODE_RESET   = 4'h0;
  localparam logic [7:0] READ_ZERO         = 8'h00;

  // --------------------------------------------------------------------
  // Limit codes
  // --------------------------------------------------------------------
  localparam logic [4:0] CODE_3A0   = 5'h1d;
  localparam logic [4:0] CODE_2A4   = 5'h17;
  localparam logic [4:0] CODE_2A0   = 5'h13;
  localparam logic [4:0] CODE_1A5   = 5'h0e;
  localparam logic [4:0] CODE_1A0   = 5'h09;
  localparam logic [4:0] CODE_0A5   = 5'h04;
  localparam logic [4:0] CODE_NONE  = 5'h00;
  localparam logic [4:0] CODE_ZERO  = 5'h00;

  // Detection field encodings
  localparam logic [1:0] CT_NONE    = 2'h0;
  localparam logic [1:0] CT_SDP     = 2'h1;
  localparam logic [1:0] CT_CDP     = 2'h2;
  localparam logic [1:0] CT_DCP     = 2'h3;
  localparam logic [2:0] PT_NONE    = 3'h0;
  localparam logic [2:0] PT_2A_B    = 3'h1;
  localparam logic [2:0] PT_0A5     = 3'h2;
  localparam logic [2:0] PT_1A      = 3'h3;
  localparam logic [2:0] PT_2A_A    = 3'h4;
  localparam logic [2:0] PT_2A4     = 3'h5;
  localparam logic [2:0] PT_3A      = 3'h6;
  localparam logic [1:0] CC_1A5     = 2'h2;
  localparam logic [1:0] CC_3A      = 2'h3;
  localparam logic [1:0] SDP_DEF    = 2'h0;
  localparam logic [1:0] SDP_0A5    = 2'h1;
  localparam logic [1:0] SDP_1A0    = 2'h2;
  localparam logic [1:0] SDP_1A5    = 2'h3;

  // --------------------------------------------------------------------
  // Modes and carriers
  // --------------------------------------------------------------------
  typedef enum logic [2:0] {
    CHG_DISABLED, CHG_IDLE, CHG_PRECHARGE, CHG_FAST, CHG_DONE
  } charger_mode_e;

  typedef enum logic [1:0] {
    SYS_BAT_PLUS_400MV, SYS_PCHG_PLUS_400MV, SYS_CURRENT_SOURCE
  } sys_target_e;

  typedef struct packed {
    logic [1:0] detected_charger_type;
    logic [2:0] proprietary_charger_type;
    logic [1:0] cc_current_status;
    logic [1:0] sdp_max_current_sel;
    logic       cdp_max_current_sel;
  } detect_s;

  typedef struct packed {
    logic [4:0] thermal;
    logic [4:0] charge;
    logic [4:0] sys_reg;
    logic [4:0] term_voltage;
  } limit_req_s;

  typedef struct packed {
    logic converter_overcurrent_flag;
    logic converter_runaway_flag;
    logic converter_power_good;
    logic bus_voltage_detect;
    logic safe_zero_volt_status;
    logic thermal_reduce_limit;
    logic thermal_cutoff_limit;
    logic sys_near_pchg_200mv;
  } analog_s;

endpackage

// ### logic/input_limit_buck_control.sv
// Input current limit selection, converter targets and reverse buck control
module input_limit_buck_control (
  input  wire logic                            i_core_clk,
  input  wire logic                            i_nrst,
  input  wire logic [7:0]                      i_reg_addr,
  input  wire logic [7:0]                      i_reg_wdata,
  input  wire logic                            i_reg_wr,
  input  wire logic                            i_reg_rd,
  output logic      [7:0]                      o_reg_rdata,
  input  wire input_limit_pkg::detect_s        i_detect,
  input  wire input_limit_pkg::limit_req_s     i_limit_req,
  input  wire input_limit_pkg::analog_s        i_analog,
  input  wire input_limit_pkg::charger_mode_e  i_charger_mode,
  input  wire logic                            i_input_valid,
  input  wire logic                            i_dual_role_enable,
  input  wire logic                            i_port_buck_request,
  input  wire logic                            i_port_vconn_request,
  input  wire logic                            i_port_attach_wait_sink,
  input  wire logic [3:0]                      i_buck_voltage_code,
  input  wire logic                            i_sink_restart_bit,
  input  wire logic                            i_source_restart_bit,
  input  wire logic                            i_force_error_restart_bit,
  input  wire logic                            i_port_restart_bit,
  output logic      [4:0]                      o_input_limit_code,
  output logic      [4:0]                      o_active_limit_code,
  output input_limit_pkg::sys_target_e         o_sys_target,
  output logic                                 o_bat_switch_closed,
  output logic                                 o_charge_reduce,
  output logic                                 o_input_cutoff,
  output logic                                 o_buck_enable,
  output logic      [3:0]                      o_buck_voltage_code,
  output logic                                 o_vconn_supply_enable,
  output logic                                 o_detect_start
);
  import input_limit_pkg::*;

  // --------------------------------------------------------------------
  // Functions
  // --------------------------------------------------------------------
  // Returns {valid, code}; first matching row of the selection table wins
  function automatic logic [5:0] auto_limit(input detect_s d);
    logic [1:0] ct;
    logic [2:0] pt;
    logic [1:0] cc;
    logic       cc_low;
    logic       pt_base;
    ct = d.detected_charger_type;
    pt = d.proprietary_charger_type;
    cc = d.cc_current_status;
    // Status 00 or 01
    cc_low = (cc < CC_1A5);
    // Types that defer to charger type
    pt_base = (pt == PT_NONE) || (pt == PT_0A5);
    if (ct == CT_NONE) begin
      auto_limit = {1'b0, CODE_NONE};
    end else if (pt == PT_3A) begin
      auto_limit = {1'b1, CODE_3A0};
    end else if (cc == CC_3A && d.sdp_max_current_sel == SDP_DEF &&
                 !d.cdp_max_current_sel) begin
      auto_limit = {1'b1, CODE_3A0};
    end else if (ct == CT_DCP && cc == CC_3A) begin
      auto_limit = {1'b1, CODE_3A0};
    end else if (pt == PT_2A4 && cc != CC_3A) begin
      auto_limit = {1'b1, CODE_2A4};
    end else if ((pt == PT_2A_A || pt == PT_2A_B) && cc != CC_3A) begin
      auto_limit = {1'b1, CODE_2A0};
    end else if (ct[1] && pt_base && cc != CC_3A) begin
      auto_limit = {1'b1, CODE_1A5};
    end else if (ct[1] && pt == PT_1A && cc == CC_1A5) begin
      auto_limit = {1'b1, CODE_1A5};
    end else if (pt == PT_1A && cc_low) begin
      auto_limit = {1'b1, CODE_1A0};
    end else if (ct == CT_SDP && pt_base && cc_low) begin
      auto_limit = {1'b1, CODE_0A5};
    end else if (ct == CT_SDP && pt == PT_NONE && !cc_low) begin
      unique case (d.sdp_max_current_sel)
        SDP_0A5: auto_limit = {1'b1, CODE_0A5};
        SDP_1A0: auto_limit = {1'b1, CODE_1A0};
        SDP_1A5: auto_limit = {1'b1, CODE_1A5};
        // Selection 00
        default: auto_limit = {1'b0, CODE_NONE};
      endcase
    end else if (ct == CT_CDP && pt == PT_NONE && cc == CC_3A &&
                 d.cdp_max_current_sel) begin
      auto_limit = {1'b1, CODE_1A5};
    end else begin
      auto_limit = {1'b0, CODE_NONE};
    end
  endfunction

  // Lower of two codes
  function automatic logic [4:0] min5(input logic [4:0] a,
                                      input logic [4:0] b);
    min5 = (a < b) ? a : b;
  endfunction

  // --------------------------------------------------------------------
  // Input synchronisers
  // --------------------------------------------------------------------
  // Stage two only is read
  analog_s sync1_reg;
  analog_s sync2_reg;

  always_ff @(posedge i_core_clk) begin
    if (!i_nrst) begin
      sync1_reg <= '0;
      sync2_reg <= '0;
    end else begin
      sync1_reg <= i_analog;
      sync2_reg <= sync1_reg;
    end
  end

  // --------------------------------------------------------------------
  // Input limit selection
  // --------------------------------------------------------------------
  logic [7:0] manual_ctrl_reg;
  // Registered detection result
  logic [4:0] auto_code_reg;
  logic       auto_valid_reg;
  logic [5:0] auto_next;
  logic [4:0] input_limit_next;
  // Force bit of manual control
  logic       force_on;

  // Re-evaluated every cycle
  assign auto_next = auto_limit(i_detect);
  assign force_on  = manual_ctrl_reg[BIT_LIMIT_FORCE];

  // Only manual control is writable
  always_ff @(posedge i_core_clk) begin
    if (!i_nrst) begin
      manual_ctrl_reg <= MANUAL_CTRL_RESET;
    end else if (i_reg_wr && i_reg_addr == ADDR_MANUAL_CTRL) begin
      manual_ctrl_reg <= i_reg_wdata;
    end
  end

  always_ff @(posedge i_core_clk) begin
    if (!i_nrst) begin
      auto_code_reg  <= CODE_NONE;
      auto_valid_reg <= 1'b0;
    end else begin
      auto_code_reg  <= auto_next[LIMIT_CODE_MSB:0];
      auto_valid_reg <= auto_next[LIMIT_CODE_MSB+1];
    end
  end

  always_comb begin
    // Force overrides detection
    if (force_on) begin
      input_limit_next = manual_ctrl_reg[LIMIT_CODE_MSB:0];
    end else if (auto_valid_reg) begin
      input_limit_next = auto_code_reg;
    end else begin
      input_limit_next = CODE_NONE;
    end
  end

  always_ff @(posedge i_core_clk) begin
    if (!i_nrst) begin
      o_input_limit_code <= CODE_NONE;
    end else begin
      // Registered once more
      o_input_limit_code <= input_limit_next;
    end
  end

  // --------------------------------------------------------------------
  // Thermal limiting and active limit
  // --------------------------------------------------------------------
  // Minimum of all requests
  logic [4:0] active_next;

  always_comb begin
    active_next = min5(o_input_limit_code, i_limit_req.thermal);
    active_next = min5(active_next, i_limit_req.charge);
    active_next = min5(active_next, i_limit_req.sys_reg);
    active_next = min5(active_next, i_limit_req.term_voltage);
    // Cutoff wins
    if (sync2_reg.thermal_cutoff_limit) begin
      active_next = CODE_ZERO;
    end
  end

  always_ff @(posedge i_core_clk) begin
    if (!i_nrst) begin
      o_active_limit_code <= CODE_ZERO;
      o_input_cutoff      <= 1'b0;
      o_charge_reduce     <= 1'b0;
    end else begin
      // One cycle later
      o_active_limit_code <= active_next;
      o_input_cutoff      <= sync2_reg.thermal_cutoff_limit;
      o_charge_reduce     <= sync2_reg.thermal_reduce_limit ||
                             sync2_reg.thermal_cutoff_limit ||
                             (i_charger_mode == CHG_PRECHARGE &&
                              sync2_reg.sys_near_pchg_200mv);
    end
  end

  // --------------------------------------------------------------------
  // System target and battery switch
  // --------------------------------------------------------------------
  always_ff @(posedge i_core_clk) begin
    if (!i_nrst) begin
      o_sys_target <= SYS_BAT_PLUS_400MV;
    // No input: battery target
    end else if (!i_input_valid) begin
      o_sys_target <= SYS_BAT_PLUS_400MV;
    end else begin
      unique case (i_charger_mode)
        CHG_PRECHARGE: o_sys_target <= SYS_PCHG_PLUS_400MV;
        CHG_FAST:      o_sys_target <= SYS_CURRENT_SOURCE;
        // Done sources current
        CHG_DONE:      o_sys_target <= SYS_CURRENT_SOURCE;
        default:       o_sys_target <= SYS_BAT_PLUS_400MV;
      endcase
    end
  end

  always_ff @(posedge i_core_clk) begin
    if (!i_nrst) begin
      o_bat_switch_closed <= 1'b0;
    end else begin
      o_bat_switch_closed <= o_buck_enable ||
                             i_charger_mode == CHG_FAST ||
                             i_charger_mode == CHG_DONE;
    end
  end

  // --------------------------------------------------------------------
  // Reverse buck
  // --------------------------------------------------------------------
  // Fault and restart state
  logic fault_now;
  logic fault_latch_reg;
  logic [2:0] fault_flags_reg;
  logic restart_req;

  // Restart bits
  assign restart_req = i_sink_restart_bit || i_source_restart_bit ||
                       i_force_error_restart_bit || i_port_restart_bit;
  // Only while running
  assign fault_now = o_buck_enable &&
                     (sync2_reg.converter_overcurrent_flag ||
                      sync2_reg.converter_runaway_flag ||
                      !sync2_reg.converter_power_good);

  // A new fault wins over a restart in the same cycle
  always_ff @(posedge i_core_clk) begin
    if (!i_nrst) begin
      fault_latch_reg <= 1'b0;
      fault_flags_reg <= '0;
    end else if (fault_now) begin
      fault_latch_reg <= 1'b1;
      fault_flags_reg <= {sync2_reg.converter_power_good,
                          sync2_reg.converter_runaway_flag,
                          sync2_reg.converter_overcurrent_flag};
    end else if (restart_req && fault_latch_reg) begin
      fault_latch_reg <= 1'b0;
      fault_flags_reg <= '0;
    end
  end

  always_ff @(posedge i_core_clk) begin
    if (!i_nrst) begin
      o_buck_enable <= 1'b0;
    end else begin
      o_buck_enable <= i_dual_role_enable && i_port_buck_request &&
                       !fault_latch_reg && !fault_now;
    end
  end

  // Code is captured only while the buck is off
  always_ff @(posedge i_core_clk) begin
    if (!i_nrst) begin
      o_buck_voltage_code <= BUCK_CODE_RESET;
    end else if (!o_buck_enable) begin
      o_buck_voltage_code <= i_buck_voltage_code;
    end
  end

  // --------------------------------------------------------------------
  // Port controls
  // --------------------------------------------------------------------
  // Entry edge of attach-wait
  logic attach_wait_d_reg;

  always_ff @(posedge i_core_clk) begin
    if (!i_nrst) begin
      attach_wait_d_reg     <= 1'b0;
      o_detect_start        <= 1'b0;
      o_vconn_supply_enable <= 1'b0;
    end else begin
      attach_wait_d_reg     <= i_port_attach_wait_sink;
      o_detect_start        <= i_port_attach_wait_sink &&
                               !attach_wait_d_reg;
      // Follows the port
      o_vconn_supply_enable <= i_port_vconn_request;
    end
  end

  // --------------------------------------------------------------------
  // Register read
  // --------------------------------------------------------------------
  // Read mux
  logic [7:0] rdata_next;

  always_comb begin
    // Unlisted reads zero
    rdata_next = READ_ZERO;
    unique case (i_reg_addr)
      // Latched cause, or live power good
      ADDR_FAULT_STATUS: begin
        rdata_next[BIT_OVERCURRENT] = fault_flags_reg[BIT_OVERCURRENT];
        rdata_next[BIT_RUNAWAY]     = fault_flags_reg[BIT_RUNAWAY];
        rdata_next[BIT_POWER_GOOD]  = fault_latch_reg ?
                                      fault_flags_reg[BIT_POWER_GOOD] :
                                      sync2_reg.converter_power_good;
      end
      // Zero while faulted
      ADDR_VBUS_DETECT: begin
        rdata_next[BIT_VBUS_DETECT] = !fault_latch_reg &&
                                      sync2_reg.bus_voltage_detect;
      end
      ADDR_SAFE_ZERO: begin
        rdata_next[BIT_SAFE_ZERO] = !fault_latch_reg &&
                                    sync2_reg.safe_zero_volt_status;
      end
      ADDR_MANUAL_CTRL: rdata_next = manual_ctrl_reg;
      ADDR_AUTO_STATUS: begin
        rdata_next[LIMIT_CODE_MSB:0] = auto_code_reg;
      end
      default: rdata_next = READ_ZERO;
    endcase
  end

  always_ff @(posedge i_core_clk) begin
    if (!i_nrst) begin
      o_reg_rdata <= READ_ZERO;
    end else if (i_reg_rd) begin
      // Held until next read
      o_reg_rdata <= rdata_next;
    end
  end

endmodule // input_limit_buck_control

// ### sim/input_limit_properties.sv
// Checker: port-level properties of the input limit and buck control block
module input_limit_props (
  input wire logic                          i_core_clk,
  input wire logic                          i_nrst,
  input wire logic                          i_reg_rd,
  input wire input_limit_pkg::limit_req_s   i_limit_req,
  input wire input_limit_pkg::analog_s      i_analog,
  input wire input_limit_pkg::charger_mode_e i_charger_mode,
  input wire logic                          i_input_valid,
  input wire logic                          i_dual_role_enable,
  input wire logic                          i_port_buck_request,
  input wire logic                          i_port_vconn_request,
  input wire logic                          i_port_attach_wait_sink,
  input wire logic [7:0]                    o_reg_rdata,
  input wire logic [4:0]                    o_active_limit_code,
  input wire input_limit_pkg::sys_target_e  o_sys_target,
  input wire logic                          o_bat_switch_closed,
  input wire logic                          o_buck_enable,
  input wire logic [3:0]                    o_buck_voltage_code,
  input wire logic                          o_vconn_supply_enable,
  input wire logic                          o_detect_start
);
  import input_limit_pkg::*;
  default clocking @(posedge i_core_clk); endclocking
  default disable iff (!i_nrst);

  // ------------------------------------------------------------------
  // Assertions and covers
  // ------------------------------------------------------------------
  a_detect_pulse: assert property ($rose(i_port_attach_wait_sink)
    |=> o_detect_start ##1 !o_detect_start) else $error("bad detect pulse");
  a_vconn_copy: assert property ($past(i_nrst) |->
    o_vconn_supply_enable == $past(i_port_vconn_request))
    else $error("vconn enable mismatch");
  a_buck_gate: assert property (
    !(i_dual_role_enable && i_port_buck_request) |=> !o_buck_enable)
    else $error("buck on without request");
  a_buck_frozen: assert property (
    $past(o_buck_enable) && o_buck_enable |-> $stable(o_buck_voltage_code))
    else $error("buck code moved while running");
  a_fault_off: assert property (
    i_analog.converter_overcurrent_flag [*4] |=> !o_buck_enable)
    else $error("buck kept on during fault");
  a_active_min: assert property ($past(i_nrst) |->
    o_active_limit_code <= $past(i_limit_req.thermal) &&
    o_active_limit_code <= $past(i_limit_req.charge) &&
    o_active_limit_code <= $past(i_limit_req.sys_reg) &&
    o_active_limit_code <= $past(i_limit_req.term_voltage))
    else $error("active limit above a request");
  a_pchg_target: assert property (
    i_input_valid && i_charger_mode == CHG_PRECHARGE
    |=> o_sys_target == SYS_PCHG_PLUS_400MV) else $error("bad pchg target");
  a_fast_source: assert property (
    i_input_valid && i_charger_mode == CHG_FAST
    |=> o_sys_target == SYS_CURRENT_SOURCE) else $error("bad fast target");
  a_switch_open: assert property ((
    i_charger_mode inside {CHG_DISABLED, CHG_IDLE} && !o_buck_enable) [*2]
    |=> !o_bat_switch_closed) else $error("battery switch closed");
  a_rdata_hold: assert property (!i_reg_rd |=> $stable(o_reg_rdata))
    else $error("read data changed without read");

  c_buck_fault: cover property (o_buck_enable ##1 !o_buck_enable);
  c_detect: cover property (o_detect_start);
  c_three_amp: cover property (o_active_limit_code == 5'h1d);
endmodule // input_limit_props

bind input_limit_buck_control input_limit_props u_props (.*);

// ### sim/port_partner_model.sv
// Model of the load and analog front end seen across the port
module port_partner_model (
  input  wire logic                     i_core_clk,
  input  wire logic                     i_buck_on,
  input  wire logic                     i_short,
  input  wire logic [1:0]               i_heat,
  input  wire logic                     i_near,
  input  wire logic                     i_runaway,
  output input_limit_pkg::analog_s      o_analog
);
  timeunit 1ns;
  timeprecision 1ns;
  import input_limit_pkg::*;

  initial o_analog = '0;

  // A short on the port drags power good down with the overcurrent flag
  always @(posedge i_core_clk) begin
    o_analog.converter_overcurrent_flag <= i_short;
    o_analog.converter_runaway_flag     <= i_runaway;
    o_analog.converter_power_good       <= !(i_short || i_runaway);
    o_analog.bus_voltage_detect         <= 1'b1;
    o_analog.safe_zero_volt_status      <= !i_buck_on;
    o_analog.thermal_reduce_limit       <= i_heat[0];
    o_analog.thermal_cutoff_limit       <= i_heat[1];
    o_analog.sys_near_pchg_200mv        <= i_near;
  end
endmodule // port_partner_model

// ### sim/test_input_limit_buck_control.sv
// Testbench: register, limit selection, mode and buck scenarios
module test_input_limit_buck_control;
  timeunit 1ns;
  timeprecision 1ns;
  import input_limit_pkg::*;

  logic i_core_clk, i_nrst, i_reg_wr, i_reg_rd, i_input_valid;
  logic i_dual_role_enable, i_port_buck_request, i_port_vconn_request;
  logic i_port_attach_wait_sink, i_sink_restart_bit, i_source_restart_bit;
  logic i_force_error_restart_bit, i_port_restart_bit;
  logic [7:0] i_reg_addr, i_reg_wdata, o_reg_rdata;
  logic [3:0] i_buck_voltage_code, o_buck_voltage_code, rst_bits;
  logic [4:0] o_input_limit_code, o_active_limit_code;
  logic o_bat_switch_closed, o_charge_reduce, o_input_cutoff;
  logic o_buck_enable, o_vconn_supply_enable, o_detect_start;
  logic short_c, near_c, runaway_c;
  logic [1:0] heat_c;
  detect_s i_detect;
  limit_req_s i_limit_req;
  analog_s i_analog;
  charger_mode_e i_charger_mode;
  sys_target_e o_sys_target;
  int mismatches, cmp_count, cycles;

  // {charger, proprietary, cc, sdp, cdp, expected code}
  localparam logic [14:0] TBL [15] = '{
    15'b01_110_00_00_0_11101, 15'b01_000_11_00_0_11101,
    15'b11_000_11_11_1_11101, 15'b01_101_10_00_0_10111,
    15'b10_100_00_00_0_10011, 15'b11_001_01_00_0_10011,
    15'b10_010_00_00_0_01110, 15'b11_011_10_00_0_01110,
    15'b01_011_01_00_0_01001, 15'b01_010_00_00_0_00100,
    15'b01_000_10_01_0_00100, 15'b01_000_11_10_0_01001,
    15'b01_000_10_11_0_01110, 15'b10_000_11_01_1_01110,
    15'b00_000_00_00_0_00000};
  localparam charger_mode_e MODES [4] =
    '{CHG_DISABLED, CHG_IDLE, CHG_FAST, CHG_DONE};
  localparam sys_target_e TGT [4] = '{SYS_BAT_PLUS_400MV,
    SYS_BAT_PLUS_400MV, SYS_CURRENT_SOURCE, SYS_CURRENT_SOURCE};

  assign {i_sink_restart_bit, i_source_restart_bit,
          i_force_error_restart_bit, i_port_restart_bit} = rst_bits;

  input_limit_buck_control uut (.*);
  port_partner_model u_partner (.i_core_clk(i_core_clk),
    .i_buck_on(o_buck_enable), .i_short(short_c), .i_heat(heat_c),
    .i_near(near_c), .i_runaway(runaway_c), .o_analog(i_analog));

  // ------------------------------------------------------------------
  // Tasks
  // ------------------------------------------------------------------
  task automatic finish_test;
    $display("mismatches %0d comparisons %0d", mismatches, cmp_count);
    if (mismatches == 0 && cmp_count > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  task automatic chk(string n, logic [7:0] e, logic [7:0] g);
    cmp_count++;
    if (g !== e) begin
      mismatches++;
      $display("unexpected %s expected %h seen %h", n, e, g);
    end
  endtask

  task automatic rd(logic [7:0] a, logic [7:0] e, string n);
    @(posedge i_core_clk);
    i_reg_addr <= a;
    i_reg_rd   <= 1'b1;
    @(posedge i_core_clk);
    i_reg_rd   <= 1'b0;
    @(negedge i_core_clk);
    chk(n, e, o_reg_rdata);
  endtask

  task automatic wr(logic [7:0] a, logic [7:0] d);
    @(posedge i_core_clk);
    i_reg_addr  <= a;
    i_reg_wdata <= d;
    i_reg_wr    <= 1'b1;
    @(posedge i_core_clk);
    i_reg_wr    <= 1'b0;
  endtask

  // Partner flop plus two sync stages
  task automatic settle;
    repeat (6) @(posedge i_core_clk);
    @(negedge i_core_clk);
  endtask

  initial begin
    i_core_clk = 1'b0;
    forever #50 i_core_clk = ~i_core_clk;
  end

  always @(posedge i_core_clk) begin
    cycles <= cycles + 1;
    if (cycles == 5000) begin
      mismatches++;
      finish_test;
    end
  end

  // ------------------------------------------------------------------
  // Main sequence
  // ------------------------------------------------------------------
  initial begin
    {i_nrst, i_reg_wr, i_reg_rd, i_dual_role_enable} = '0;
    {i_port_buck_request, i_port_vconn_request, runaway_c} = '0;
    {i_port_attach_wait_sink, short_c, near_c, heat_c, rst_bits} = '0;
    {i_reg_addr, i_reg_wdata, i_buck_voltage_code, i_detect} = '0;
    {mismatches, cmp_count, cycles} = '0;
    i_input_valid = 1'b1;
    i_limit_req = '1;
    i_charger_mode = CHG_DISABLED;
    repeat (2) @(posedge i_core_clk);
    i_nrst <= 1'b1;
    rd(ADDR_MANUAL_CTRL, MANUAL_CTRL_RESET, "manual_reset");
    rd(8'h30, READ_ZERO, "unmapped");
    wr(ADDR_AUTO_STATUS, 8'h1f);
    rd(ADDR_AUTO_STATUS, READ_ZERO, "auto_read_only");
    for (int k = 0; k < 15; k++) begin
      @(posedge i_core_clk);
      i_detect <= TBL[k][14:5];
      settle;
      chk("limit", 8'(TBL[k][4:0]), 8'(o_input_limit_code));
      chk("active", 8'(TBL[k][4:0]), 8'(o_active_limit_code));
      rd(ADDR_AUTO_STATUS, 8'(TBL[k][4:0]), "auto_code");
    end
    wr(ADDR_MANUAL_CTRL, 8'h85);
    rd(ADDR_MANUAL_CTRL, 8'h85, "manual_ctrl");
    @(posedge i_core_clk);
    i_limit_req.thermal <= 5'h03;
    settle;
    chk("forced", 8'h05, 8'(o_input_limit_code));
    chk("min_thermal", 8'h03, 8'(o_active_limit_code));
    @(posedge i_core_clk);
    i_limit_req.term_voltage <= 5'h02;
    heat_c <= 2'b01;
    settle;
    chk("min_term", 8'h02, 8'(o_active_limit_code));
    chk("charge_reduce", 8'h01, 8'(o_charge_reduce));
    @(posedge i_core_clk);
    heat_c <= 2'b11;
    settle;
    chk("cutoff", 8'h01, 8'(o_input_cutoff));
    chk("cutoff_limit", 8'h00, 8'(o_active_limit_code));
    @(posedge i_core_clk);
    heat_c <= 2'b00;
    i_limit_req <= '1;
    i_charger_mode <= CHG_PRECHARGE;
    near_c <= 1'b1;
    wr(ADDR_MANUAL_CTRL, 8'h00);
    settle;
    chk("pchg_target", 8'(SYS_PCHG_PLUS_400MV), 8'(o_sys_target));
    chk("pchg_reduce", 8'h01, 8'(o_charge_reduce));
    @(posedge i_core_clk);
    i_input_valid <= 1'b0;
    settle;
    chk("no_input", 8'(SYS_BAT_PLUS_400MV), 8'(o_sys_target));
    for (int k = 0; k < 4; k++) begin
      @(posedge i_core_clk);
      i_charger_mode <= MODES[k];
      i_input_valid <= 1'b1;
      settle;
      chk("target", 8'(TGT[k]), 8'(o_sys_target));
      chk("switch", 8'(k > 1), 8'(o_bat_switch_closed));
    end
    @(posedge i_core_clk);
    i_charger_mode <= CHG_DISABLED;
    {i_dual_role_enable, i_port_buck_request} <= 2'b11;
    i_buck_voltage_code <= 4'h7;
    settle;
    chk("buck_on", 8'h01, 8'(o_buck_enable));
    chk("buck_switch", 8'h01, 8'(o_bat_switch_closed));
    @(posedge i_core_clk);
    i_buck_voltage_code <= 4'h9;
    settle;
    chk("buck_code", 8'h07, 8'(o_buck_voltage_code));
    for (int k = 0; k < 4; k++) begin
      @(posedge i_core_clk);
      {runaway_c, short_c} <= k[0] ? 2'b10 : 2'b01;
      settle;
      chk("fault_off", 8'h00, 8'(o_buck_enable));
      rd(ADDR_FAULT_STATUS, 8'(k[0] ? 2'b10 : 2'b01), "fault_cause");
      rd(ADDR_VBUS_DETECT, READ_ZERO, "vbus_detect");
      rd(ADDR_SAFE_ZERO, READ_ZERO, "safe_zero");
      @(posedge i_core_clk);
      {runaway_c, short_c} <= 2'b00;
      settle;
      chk("held_off", 8'h00, 8'(o_buck_enable));
      @(posedge i_core_clk);
      rst_bits <= 4'h1 << k;
      @(posedge i_core_clk);
      rst_bits <= 4'h0;
      settle;
      chk("restart", 8'h01, 8'(o_buck_enable));
      rd(ADDR_FAULT_STATUS, 8'h04, "fault_clear");
      rd(ADDR_VBUS_DETECT, 8'h01, "vbus_live");
    end
    chk("buck_code_new", 8'h09, 8'(o_buck_voltage_code));
    @(posedge i_core_clk);
    i_port_attach_wait_sink <= 1'b1;
    i_port_vconn_request <= 1'b1;
    @(posedge i_core_clk);
    @(negedge i_core_clk);
    chk("detect_start", 8'h01, 8'(o_detect_start));
    chk("vconn", 8'h01, 8'(o_vconn_supply_enable));
    @(negedge i_core_clk);
    chk("detect_end", 8'h00, 8'(o_detect_start));
    @(posedge i_core_clk);
    i_nrst <= 1'b0;
    repeat (2) @(posedge i_core_clk);
    i_nrst <= 1'b1;
    @(negedge i_core_clk);
    chk("reset_buck", 8'h00, 8'(o_buck_enable));
    finish_test;
  end
endmodule // test_input_limit_buck_control
